// ### hw/tds_seq.sv
`timescale 1ns/100ps
// How it works
// - Each transfer pauses at centre-off for a selectable 0 s or 5 s, default 0 s.
// - The same centre-off pause serves transfers toward normal and toward alternate.
// - Auto-return runs the re-transfer delay while watching both sources throughout.
// - Normal failing during the re-transfer delay stops it and cancels the return.
// - Replacement failing with normal healthy during the delay returns at once.
// - Re-transfer delay defaults to one minute, set from 0 to 60 minutes, fixed.
// - Generator mode waits the start delay, default 3 s, before commanding start.
// - Start delay applies only with auxiliary power or the start module selected.
// - Load-shed output rises after the load-shed delay, default 0 s, in both modes.
// - After normal closes, the cool-down delay runs before the generator stop command.
// - After a restart in generator mode the cool-down delay runs before stop.
// - On return to normal, cool-down starts only if generator start is commanded and was armed or second source stayed healthy.
module tds_seq
  import tds_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES,
  parameter bit FIXED_SELECTS = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire tds_src_t src_in,
  output tds_cmd_t cmd_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    tds_state_t st;
    tds_src_t sync1;
    tds_src_t sync2;
    tds_src_t sync3;
    tds_src_t filt;
    tds_cmd_t cmd;
    logic [2:0] ctrl;
    logic [23:0] dly;
    logic ack;
    logic [31:0] rdata;
    logic [24:0] tick_cnt;
    logic tick;
    logic gen_armed;
    logic alt_stable;
    logic boot;
  } tds_core_t;

  tds_core_t s_r;
  tds_core_t s_nxt;

  logic seq_start, seq_abort, seq_done;
  logic cool_start, cool_abort, cool_done;
  logic shed_start, shed_abort, shed_done;
  logic [SECS_W-1:0] seq_secs;

  // Maps a delay select to seconds; selects above the table clamp to the top.
  function automatic logic [SECS_W-1:0] sel_secs(input logic [3:0] sel);
    logic [SECS_W-1:0] v;
    case (sel)
      4'h0: v = 12'h000;
      4'h1: v = 12'h001;
      4'h2: v = 12'h002;
      4'h3: v = 12'h003;
      4'h4: v = 12'h005;
      4'h5: v = 12'h00A;
      4'h6: v = 12'h014;
      4'h7: v = 12'h01E;
      default: v = 12'h03C;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic n_ok, a_ok, ug, auto_ret, gs_en, acc;
    logic [SECS_W-1:0] co_secs, retx_secs, gs_secs;
    logic [31:0] wmask;
    s_nxt = s_r;
    seq_start = 1'b0;
    seq_abort = 1'b0;
    seq_secs = '0;
    cool_start = 1'b0;
    cool_abort = 1'b0;
    shed_start = 1'b0;
    shed_abort = 1'b0;
    n_ok = s_r.filt.normal_ok;
    a_ok = s_r.filt.alt_ok;
    ug = s_r.ctrl[CTRL_UG_BIT];
    auto_ret = s_r.ctrl[CTRL_AUTO_RET_BIT];
    gs_en = s_r.filt.aux_power | s_r.filt.gen_module;
    co_secs = s_r.ctrl[CTRL_CO5_BIT] ? CO_DELAY_S : 12'h000;
    retx_secs = 12'(sel_secs(s_r.dly[DLY_RETX_LSB+:4]) * SECS_PER_MIN);
    gs_secs = sel_secs(s_r.dly[DLY_GS_LSB+:4]);

    // Pin inputs: three stages, a change counts once stages two and three agree.
    s_nxt.sync1 = src_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    for (int i = 0; i < $bits(tds_src_t); i++) begin
      if (s_r.sync2[i] == s_r.sync3[i]) begin
        s_nxt.filt[i] = s_r.sync3[i];
      end
    end

    // One-second timebase.
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt >= 25'(TICK_COUNT - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 25'h000_0001;
    end

    // Position commands are levels held only in their states.
    s_nxt.cmd.to_off = 1'b0;
    s_nxt.cmd.to_alt = 1'b0;
    s_nxt.cmd.to_normal = 1'b0;

    case (s_r.st)
      S_NORMAL: begin
        if (!n_ok) begin
          shed_start = 1'b1;
          if (ug && gs_en) begin
            seq_start = 1'b1;
            seq_secs = gs_secs;
            s_nxt.st = S_GEN_DLY;
          end else begin
            if (ug) begin
              cool_abort = 1'b1;
              s_nxt.cmd.gen_start = 1'b1;
              s_nxt.cmd.gen_stop = 1'b0;
              s_nxt.gen_armed = 1'b1;
            end
            s_nxt.st = S_ALT_WAIT;
          end
        end
      end
      S_GEN_DLY: begin
        if (n_ok) begin
          seq_abort = 1'b1;
          shed_abort = 1'b1;
          s_nxt.cmd.load_shed = 1'b0;
          s_nxt.st = S_NORMAL;
        end else if (seq_done) begin
          cool_abort = 1'b1;
          s_nxt.cmd.gen_start = 1'b1;
          s_nxt.cmd.gen_stop = 1'b0;
          s_nxt.gen_armed = 1'b1;
          s_nxt.st = S_ALT_WAIT;
        end
      end
      S_ALT_WAIT: begin
        if (n_ok) begin
          shed_abort = 1'b1;
          s_nxt.cmd.load_shed = 1'b0;
          if (s_r.cmd.gen_start && s_r.gen_armed) begin
            cool_start = 1'b1;
          end
          s_nxt.st = S_NORMAL;
        end else if (a_ok) begin
          s_nxt.st = S_OFF_A;
        end
      end
      S_OFF_A: begin
        s_nxt.cmd.to_off = 1'b1;
        if (s_r.filt.pos_off) begin
          seq_start = 1'b1;
          seq_secs = co_secs;
          s_nxt.cmd.to_off = 1'b0;
          s_nxt.st = S_CO_A;
        end
      end
      S_CO_A: begin
        if (seq_done) begin
          s_nxt.st = S_CLOSE_A;
        end
      end
      S_CLOSE_A: begin
        s_nxt.cmd.to_alt = 1'b1;
        if (s_r.filt.pos_alt) begin
          s_nxt.cmd.to_alt = 1'b0;
          s_nxt.st = S_ALT;
        end
      end
      S_ALT: begin
        if (!a_ok && n_ok) begin
          s_nxt.st = S_OFF_N;
        end else if (auto_ret && n_ok) begin
          seq_start = 1'b1;
          seq_secs = retx_secs;
          s_nxt.alt_stable = a_ok;
          s_nxt.st = S_RETX;
        end
      end
      S_RETX: begin
        s_nxt.alt_stable = s_r.alt_stable & a_ok;
        if (!n_ok) begin
          seq_abort = 1'b1;
          s_nxt.st = S_ALT;
        end else if (!a_ok) begin
          seq_abort = 1'b1;
          s_nxt.st = S_OFF_N;
        end else if (seq_done) begin
          s_nxt.st = S_OFF_N;
        end
      end
      S_OFF_N: begin
        s_nxt.cmd.to_off = 1'b1;
        if (s_r.filt.pos_off) begin
          seq_start = 1'b1;
          seq_secs = co_secs;
          s_nxt.cmd.to_off = 1'b0;
          s_nxt.st = S_CO_N;
        end
      end
      S_CO_N: begin
        if (seq_done) begin
          s_nxt.st = S_CLOSE_N;
        end
      end
      S_CLOSE_N: begin
        s_nxt.cmd.to_normal = 1'b1;
        if (s_r.filt.pos_normal) begin
          s_nxt.cmd.to_normal = 1'b0;
          shed_abort = 1'b1;
          s_nxt.cmd.load_shed = 1'b0;
          if (s_r.cmd.gen_start && (s_r.gen_armed || s_r.alt_stable)) begin
            cool_start = 1'b1;
          end
          s_nxt.st = S_NORMAL;
        end
      end
      default: begin
        s_nxt.st = S_NORMAL;
      end
    endcase

    if (shed_done && !shed_abort) begin
      s_nxt.cmd.load_shed = 1'b1;
    end

    // Restart in generator mode: cool-down runs before the stop command.
    if (s_r.boot && s_r.tick) begin
      s_nxt.boot = 1'b0;
      if (ug && !cool_abort && !s_nxt.cmd.gen_start) begin
        cool_start = 1'b1;
      end
    end

    if (cool_done && !cool_abort) begin
      s_nxt.cmd.gen_start = 1'b0;
      s_nxt.cmd.gen_stop = 1'b1;
      s_nxt.gen_armed = 1'b0;
      s_nxt.alt_stable = 1'b0;
    end

    // Avalon slave: one wait state, then the request is taken.
    acc = (avs_read || avs_write) && !s_r.ack;
    s_nxt.ack = acc;
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    if (acc && avs_read) begin
      s_nxt.rdata = '0;
      case (avs_address)
        CTRL_OFS: s_nxt.rdata[2:0] = s_r.ctrl;
        DELAY_OFS: s_nxt.rdata[23:0] = s_r.dly;
        STATUS_OFS: begin
          s_nxt.rdata[STAT_STATE_LSB+:4] = s_r.st;
          s_nxt.rdata[STAT_CMD_LSB+:6] = s_r.cmd;
          s_nxt.rdata[STAT_IN_LSB+:7] = s_r.filt;
        end
        default: ;
      endcase
    end
    if (acc && avs_write) begin
      case (avs_address)
        CTRL_OFS: begin
          s_nxt.ctrl = (s_r.ctrl & ~wmask[2:0]) | (avs_writedata[2:0] & wmask[2:0]);
        end
        DELAY_OFS: begin
          s_nxt.dly = (s_r.dly & ~wmask[23:0]) | (avs_writedata[23:0] & wmask[23:0]);
          if (FIXED_SELECTS) begin
            s_nxt.dly[7:0] = s_r.dly[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= S_NORMAL;
      s_r.ctrl <= CTRL_RST;
      s_r.dly <= {COOL_S_RST, SHED_S_RST, GS_SEL_RST, RETX_SEL_RST};
      s_r.boot <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Timers
  // ==========================================================================
  tds_timer u_seq_tmr (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(s_r.tick),
    .start(seq_start),
    .abort(seq_abort),
    .secs(seq_secs),
    .busy(),
    .done(seq_done)
  );

  tds_timer u_cool_tmr (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(s_r.tick),
    .start(cool_start),
    .abort(cool_abort),
    .secs({4'h0, s_r.dly[DLY_COOL_LSB+:8]}),
    .busy(),
    .done(cool_done)
  );

  tds_timer u_shed_tmr (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(s_r.tick),
    .start(shed_start),
    .abort(shed_abort),
    .secs({4'h0, s_r.dly[DLY_SHED_LSB+:8]}),
    .busy(),
    .done(shed_done)
  );

  assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
  assign avs_readdata = s_r.rdata;
  assign cmd_out = s_r.cmd;

endmodule

// ### shared/tds_pkg.sv
package tds_pkg;

  // ==========================================================================
  // Timebase
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1_000_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SECS_W = 12;

  // ==========================================================================
  // Delay figures in seconds and reset select codes
  // ==========================================================================
  localparam logic [SECS_W-1:0] CO_DELAY_S = 12'h005;
  localparam logic [SECS_W-1:0] SECS_PER_MIN = 12'h03C;
  localparam logic [3:0] RETX_SEL_RST = 4'h1;
  localparam logic [3:0] GS_SEL_RST = 4'h3;
  localparam logic [7:0] SHED_S_RST = 8'h00;
  localparam logic [7:0] COOL_S_RST = 8'h3C;

  // ==========================================================================
  // Register map, byte addresses
  // ==========================================================================
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] DELAY_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;

  localparam int CTRL_AUTO_RET_BIT = 0;
  localparam int CTRL_UG_BIT = 1;
  localparam int CTRL_CO5_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  localparam int DLY_RETX_LSB = 0;
  localparam int DLY_GS_LSB = 4;
  localparam int DLY_SHED_LSB = 8;
  localparam int DLY_COOL_LSB = 16;

  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CMD_LSB = 4;
  localparam int STAT_IN_LSB = 10;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic gen_module;
    logic aux_power;
    logic pos_alt;
    logic pos_off;
    logic pos_normal;
    logic alt_ok;
    logic normal_ok;
  } tds_src_t;

  typedef struct packed {
    logic load_shed;
    logic gen_stop;
    logic gen_start;
    logic to_alt;
    logic to_off;
    logic to_normal;
  } tds_cmd_t;

  typedef enum logic [3:0] {
    S_NORMAL = 4'h0,
    S_GEN_DLY = 4'h1,
    S_ALT_WAIT = 4'h2,
    S_OFF_A = 4'h3,
    S_CO_A = 4'h4,
    S_CLOSE_A = 4'h5,
    S_ALT = 4'h6,
    S_RETX = 4'h7,
    S_OFF_N = 4'h8,
    S_CO_N = 4'h9,
    S_CLOSE_N = 4'hA
  } tds_state_t;

endpackage

// ### hw/tds_timer.sv
`timescale 1ns/100ps
module tds_timer
  import tds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  input wire logic [SECS_W-1:0] secs,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [SECS_W-1:0] cnt;
  } tds_tmr_t;

  tds_tmr_t s_r;
  tds_tmr_t s_nxt;

  // A zero setting finishes on the first tick after the start.
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = secs;
    end else if (abort) begin
      s_nxt.busy = 1'b0;
    end else if (s_r.busy && tick) begin
      if (s_r.cnt <= 12'h001) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign done = s_r.done;

endmodule

// ### test/tds_switch_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Switch mechanism: takes three cycles to reach a commanded position.
module tds_switch_model
  import tds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire tds_cmd_t cmd,
  output logic [2:0] pos
);
  logic [1:0] cnt_r;
  logic go;

  // The position order is alternate, centre-off, normal.
  // The mechanism rests at centre-off until a new target is commanded.
  assign go = (cmd.to_off && !pos[1]) || ((cmd.to_alt || cmd.to_normal) && pos[1]);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pos <= 3'h1;
      cnt_r <= 2'h0;
    end else if (!go) begin
      cnt_r <= 2'h0;
    end else if (cnt_r == 2'h2) begin
      cnt_r <= 2'h0;
      pos <= cmd.to_off ? 3'h2 : (cmd.to_alt ? 3'h4 : 3'h1);
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

// ### test/tds_seq_asserts.sv
`timescale 1ns/100ps
// ==========================================================================
// Port checks
module tds_seq_chk
  import tds_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire tds_src_t src_in,
  input wire tds_cmd_t cmd_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_WAIT_FIRST:
    assert property (($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest)
    else $error("first request cycle not stalled");
  AST_WAIT_ONE:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request stalled more than one cycle");
  AST_ALT_FROM_OFF:
    assert property ($rose(cmd_out.to_alt) |-> src_in.pos_off)
    else $error("alternate commanded away from centre-off");
  AST_NORM_FROM_OFF:
    assert property ($rose(cmd_out.to_normal) |-> src_in.pos_off)
    else $error("normal commanded away from centre-off");
  AST_ONE_TARGET:
    assert property (!(cmd_out.to_alt && cmd_out.to_normal))
    else $error("both closing commands active");
  AST_STOP_AT_NORMAL:
    assert property ($rose(cmd_out.gen_stop) |-> src_in.pos_normal)
    else $error("generator stop while normal open");
  AST_START_STOP_EXCL:
    assert property (!(cmd_out.gen_start && cmd_out.gen_stop))
    else $error("generator start and stop together");
  AST_RETX_NEEDS_NORMAL:
    assert property ($rose(cmd_out.to_off) && src_in.pos_alt |-> $past(src_in.normal_ok, 6))
    else $error("left alternate with normal failed");
endmodule

bind tds_seq tds_seq_chk i_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .src_in(src_in),
  .cmd_out(cmd_out)
);

// ### test/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
// ==========================================================================
// Sequencer bench
module testbench
  import tds_pkg::*;
;
  localparam int TK = 8;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, nok, aok, aux, gm;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0] pos;
  tds_src_t src_in;
  tds_cmd_t cmd_out;
  int n_mismatch, num_checks, n;

  assign src_in = {gm, aux, pos, aok, nok};

  tds_seq #(.TICK_COUNT(TK), .FIXED_SELECTS(1'b1)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_in(src_in), .cmd_out(cmd_out)
  );
  tds_switch_model i_mech (.sys_clk(sys_clk), .rst(rst), .cmd(cmd_out), .pos(pos));

  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Waits for one command bit to reach a level; n holds the cycles spent.
  task wt(input int b, input logic v, input int lim);
    n = 0;
    while (cmd_out[b] !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(cmd_out[b], v);
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    close_out;
  end

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    nok = 1'b1;
    aok = 1'b0;
    aux = 1'b1;
    gm = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h0000_0002);
    bus(1'b1, DELAY_OFS, 32'h0004_0031);
    wt(4, 1'b1, 70 * TK);
    `CHK(n >= 2 * TK, 1'b1);
    `CHK(cmd_out.gen_start, 1'b0);
    $display("restart cool-down test done");
    bus(1'b0, CTRL_OFS, 32'h0000_0000);
    `CHK(q, 32'h0000_0002);
    bus(1'b1, DELAY_OFS, 32'h0004_00FF);
    bus(1'b0, DELAY_OFS, 32'h0000_0000);
    `CHK(q, 32'h0004_0031);
    bus(1'b0, 4'hC, 32'h0000_0000);
    `CHK(q, 32'h0000_0000);
    bus(1'b0, STATUS_OFS, 32'h0000_0000);
    `CHK(q[3:0], S_NORMAL);
    $display("register test done");
    bus(1'b1, CTRL_OFS, 32'h0000_0007);
    nok <= 1'b0;
    wt(3, 1'b1, 8 * TK);
    `CHK(n >= 2 * TK, 1'b1);
    `CHK(n <= 5 * TK, 1'b1);
    `CHK(cmd_out.load_shed, 1'b1);
    aok <= 1'b1;
    wt(1, 1'b1, 4 * TK);
    wt(2, 1'b1, 10 * TK);
    `CHK(n >= 4 * TK, 1'b1);
    wt(2, 1'b0, 2 * TK);
    $display("generator transfer test done");
    nok <= 1'b1;
    repeat (10 * TK) @(posedge sys_clk);
    nok <= 1'b0;
    repeat (70 * TK) @(posedge sys_clk);
    `CHK(cmd_out.to_off, 1'b0);
    `CHK(pos, 3'h4);
    nok <= 1'b1;
    repeat (20 * TK) @(posedge sys_clk);
    aok <= 1'b0;
    wt(1, 1'b1, 3 * TK);
    wt(0, 1'b1, 10 * TK);
    `CHK(n >= 4 * TK, 1'b1);
    wt(0, 1'b0, 2 * TK);
    `CHK(cmd_out.load_shed, 1'b0);
    wt(4, 1'b1, 8 * TK);
    `CHK(n >= 2 * TK, 1'b1);
    $display("abort and return test done");
    bus(1'b1, CTRL_OFS, 32'h0000_0001);
    aok <= 1'b1;
    repeat (TK) @(posedge sys_clk);
    nok <= 1'b0;
    wt(2, 1'b1, 4 * TK);
    wt(2, 1'b0, 2 * TK);
    `CHK(cmd_out.gen_start, 1'b0);
    nok <= 1'b1;
    wt(1, 1'b1, 70 * TK);
    `CHK(n >= 59 * TK, 1'b1);
    `CHK(n <= 62 * TK, 1'b1);
    wt(0, 1'b1, 3 * TK);
    wt(0, 1'b0, 2 * TK);
    $display("auto-return test done");
    aok <= 1'b0;
    aux <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h0000_0002);
    repeat (TK) @(posedge sys_clk);
    nok <= 1'b0;
    wt(3, 1'b1, 2 * TK);
    `CHK(n <= TK, 1'b1);
    nok <= 1'b1;
    wt(4, 1'b1, 8 * TK);
    `CHK(cmd_out.load_shed, 1'b0);
    gm <= 1'b1;
    repeat (TK) @(posedge sys_clk);
    nok <= 1'b0;
    wt(3, 1'b1, 8 * TK);
    `CHK(n >= 2 * TK, 1'b1);
    nok <= 1'b1;
    wt(4, 1'b1, 8 * TK);
    $display("start option test done");
    close_out;
  end
endmodule
